// ### smp_port.sv
// Purpose: byte-wide serial peripheral port, master or slave
// Assumes: pins sampled through two flops; registers on a strobe port
// Notes: engine held idle while the module enable bit is low
`timescale 1ns/10ps
module smp_port
    import smp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire smp_bus_type bus,
    output logic [7:0] rd_data,
    // pins
    input wire smp_pins_type pin_in,
    output smp_pins_type pin_out,
    output smp_pins_type pin_oe,
    // interrupt request
    output logic irq
);

    // ******************************
    // declarations
    // ******************************
    logic [3:0] pins_s;
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic sel_s;
    logic [7:0] control_reg;
    logic [7:0] ien_low_reg;
    logic [7:0] ien_high_reg;
    logic [7:0] open_drain_reg;
    logic [7:0] direction_reg;
    logic [7:0] data_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_reg;
    logic done_reg;
    logic coll_reg;
    logic sel_err_reg;
    logic fault_reg;
    logic status_seen_reg;
    logic wait_sel_high_reg;
    smp_state_type state_reg;
    logic [3:0] edge_cnt_reg;
    logic [6:0] div_cnt_reg;
    logic sck_lvl_reg;
    logic sck_prev_reg;
    logic [7:0] rd_data_reg;
    logic [3:0] pin_out_reg;
    logic [3:0] pin_oe_reg;
    logic irq_reg;
    logic enable;
    logic master;
    logic cpha;
    logic sel_func;
    logic [2:0] rate;
    logic [6:0] half_last;
    logic busy;
    logic wr_data;
    logic rd_status;
    logic rd_data_hit;
    logic flag_clear;
    logic slave_sel;
    logic edge_ev;
    logic sample_ev;
    logic shift_ev;
    logic last_ev;
    logic master_fault;
    logic slave_fault;
    logic sel_err_ev;
    logic [7:0] rx_next;
    logic [3:0] drive_val;
    logic [3:0] drive_od;
    logic [3:0] drive_dir;

    // ******************************
    // pin synchronisers
    // ******************************
    smp_sync2 #(
        .WIDTH(4)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pins_s)
    );

    assign sck_s = pins_s[3];
    assign mosi_s = pins_s[2];
    assign miso_s = pins_s[1];
    assign sel_s = pins_s[0];

    // ******************************
    // decode
    // ******************************
    assign enable = control_reg[CTL_ENABLE];
    assign master = control_reg[CTL_MASTER];
    assign cpha = control_reg[CTL_CPHA];
    assign sel_func = ~control_reg[CTL_SEL_DIS];
    assign busy = (state_reg == ST_SHIFT);

    always_comb begin
        rate = {control_reg[CTL_RATE2], control_reg[CTL_RATE1], control_reg[CTL_RATE0]};
        if (rate > RATE_MAX) begin
            rate = RATE_MAX;
        end
        half_last = (7'h01 << rate) - 7'h01;
    end

    // register accesses, blocked for core registers while disabled
    assign wr_data = bus.wr & (bus.addr == ADDR_DATA) & enable;
    assign rd_status = bus.rd & (bus.addr == ADDR_STATUS) & enable;
    assign rd_data_hit = bus.rd & (bus.addr == ADDR_DATA) & enable;
    assign flag_clear = rd_data_hit & status_seen_reg;

    // ******************************
    // edge events
    // ******************************
    assign slave_sel = ~sel_func | ~sel_s;

    always_comb begin
        if (!enable) begin
            edge_ev = 1'b0;
        end else if (master) begin
            edge_ev = busy & (div_cnt_reg == half_last);
        end else begin
            edge_ev = slave_sel & (sck_s != sck_prev_reg);
        end
    end

    // even count is a leading edge
    assign sample_ev = edge_ev & (edge_cnt_reg[0] == cpha);
    assign shift_ev = edge_ev & (edge_cnt_reg[0] ^ cpha) & (edge_cnt_reg != 4'h0);
    assign last_ev = edge_ev & (edge_cnt_reg == EDGE_LAST);
    assign rx_next = {rx_reg[6:0], master ? miso_s : mosi_s};
    assign master_fault = enable & master & busy & sel_func & ~sel_s;
    assign slave_fault = enable & ~master & busy & sel_func & sel_s;
    assign sel_err_ev = enable & ~master & ~cpha & sel_func & wait_sel_high_reg & edge_ev;

    // ******************************
    // configuration registers
    // ******************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            control_reg <= CONTROL_RST;
            ien_low_reg <= IRQ_EN_RST;
            ien_high_reg <= IRQ_EN_RST;
            open_drain_reg <= OPEN_DRAIN_RST;
            direction_reg <= DIRECTION_RST;
        end else if (bus.wr) begin
            case (bus.addr)
                ADDR_CONTROL: control_reg <= bus.wdata;
                ADDR_IRQ_EN_LOW: ien_low_reg <= bus.wdata;
                ADDR_IRQ_EN_HIGH: ien_high_reg <= bus.wdata;
                ADDR_OPEN_DRAIN: open_drain_reg <= bus.wdata;
                ADDR_DIRECTION: direction_reg <= bus.wdata;
                default: control_reg <= control_reg;
            endcase
        end
    end

    // ******************************
    // transfer engine
    // ******************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            edge_cnt_reg <= 4'h0;
        end else if (!enable || master_fault || slave_fault) begin
            state_reg <= ST_IDLE;
            edge_cnt_reg <= 4'h0;
        end else if (master && !busy && wr_data) begin
            state_reg <= ST_SHIFT;
            edge_cnt_reg <= 4'h0;
        end else if (!master && !slave_sel) begin
            state_reg <= ST_IDLE;
            edge_cnt_reg <= 4'h0;
        end else if (last_ev) begin
            state_reg <= ST_IDLE;
            edge_cnt_reg <= 4'h0;
        end else if (edge_ev) begin
            state_reg <= ST_SHIFT;
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
        end
    end

    // master clock divider and driven clock level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= 7'h00;
            sck_lvl_reg <= 1'b0;
        end else if (!busy || !master) begin
            div_cnt_reg <= 7'h00;
            sck_lvl_reg <= control_reg[CTL_CPOL];
        end else if (edge_ev) begin
            div_cnt_reg <= 7'h00;
            sck_lvl_reg <= ~sck_lvl_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
        end
    end

    // slave clock edge tracking
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
        end
    end

    // transmit and receive shifters
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shift_reg <= 8'h00;
            rx_reg <= 8'h00;
        end else begin
            if (wr_data && !busy) begin
                shift_reg <= bus.wdata;
            end else if (shift_ev) begin
                shift_reg <= {shift_reg[6:0], 1'b0};
            end
            if (sample_ev) begin
                rx_reg <= rx_next;
            end
        end
    end

    // received byte lands in the data register at byte end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_reg <= DATA_RST;
        end else if (last_ev) begin
            data_reg <= sample_ev ? rx_next : rx_reg;
        end
    end

    // ******************************
    // status flags
    // ******************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done_reg <= 1'b0;
            coll_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            done_reg <= last_ev | (done_reg & ~flag_clear);
            coll_reg <= (wr_data & busy) | (coll_reg & ~flag_clear);
            fault_reg <= master_fault | slave_fault | (fault_reg & ~flag_clear);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_seen_reg <= 1'b0;
        end else if (rd_status) begin
            status_seen_reg <= 1'b1;
        end else if (rd_data_hit || !enable) begin
            status_seen_reg <= 1'b0;
        end
    end

    // cleared only by disabling the module
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_err_reg <= 1'b0;
        end else if (!enable) begin
            sel_err_reg <= 1'b0;
        end else if (sel_err_ev) begin
            sel_err_reg <= 1'b1;
        end
    end

    // select must rise between bytes in phase-zero slave mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_sel_high_reg <= 1'b0;
        end else if (!enable || sel_s) begin
            wait_sel_high_reg <= 1'b0;
        end else if (last_ev && !master) begin
            wait_sel_high_reg <= 1'b1;
        end
    end

    // ******************************
    // read port
    // ******************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= 8'h00;
        end else if (!bus.rd) begin
            rd_data_reg <= 8'h00;
        end else begin
            case (bus.addr)
                ADDR_STATUS: rd_data_reg <= enable ?
                    {done_reg, coll_reg, sel_err_reg, fault_reg, 4'h0} : 8'h00;
                ADDR_DATA: rd_data_reg <= enable ? data_reg : 8'h00;
                ADDR_CONTROL: rd_data_reg <= control_reg;
                ADDR_IRQ_EN_LOW: rd_data_reg <= ien_low_reg;
                ADDR_IRQ_EN_HIGH: rd_data_reg <= ien_high_reg;
                ADDR_OPEN_DRAIN: rd_data_reg <= open_drain_reg;
                ADDR_DIRECTION: rd_data_reg <= direction_reg;
                default: rd_data_reg <= 8'h00;
            endcase
        end
    end

    // ******************************
    // interrupt request
    // ******************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= ien_low_reg[IEN_GLOBAL] & ien_high_reg[IEN_PORT]
                & (done_reg | fault_reg);
        end
    end

    // ******************************
    // pin drivers
    // ******************************
    // order: sck, mosi, miso, select
    assign drive_val = {sck_lvl_reg, shift_reg[7], shift_reg[7], 1'b1};
    assign drive_od = {open_drain_reg[OD_SCK], open_drain_reg[OD_MOSI],
        open_drain_reg[OD_MISO], 1'b0};
    assign drive_dir = {direction_reg[DIR_SCK], direction_reg[DIR_MOSI],
        direction_reg[DIR_MISO], direction_reg[DIR_SEL]};

    for (genvar i = 0; i < 4; i++) begin : g_pin
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                pin_out_reg[i] <= 1'b0;
                pin_oe_reg[i] <= 1'b0;
            end else begin
                // open drain only pulls low
                pin_out_reg[i] <= drive_val[i] & ~drive_od[i];
                pin_oe_reg[i] <= drive_dir[i] & (~drive_od[i] | ~drive_val[i]);
            end
        end
    end

    assign rd_data = rd_data_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign irq = irq_reg;

endmodule : smp_port

// ### smp_pkg.sv
// Purpose: constants and types of the serial peripheral port
// Assumes: 8-bit register space reached over a plain strobe port
// Notes: offsets are the register addresses as seen on that port
package smp_pkg;

    // ******************************
    // register addresses
    // ******************************
    localparam logic [7:0] ADDR_IRQ_EN_LOW = 8'hA8;
    localparam logic [7:0] ADDR_IRQ_EN_HIGH = 8'hB8;
    localparam logic [7:0] ADDR_STATUS = 8'hE1;
    localparam logic [7:0] ADDR_CONTROL = 8'hE2;
    localparam logic [7:0] ADDR_DATA = 8'hE3;
    localparam logic [7:0] ADDR_OPEN_DRAIN = 8'hE4;
    localparam logic [7:0] ADDR_DIRECTION = 8'hF9;

    // ******************************
    // field positions
    // ******************************
    localparam int CTL_RATE2 = 7;
    localparam int CTL_ENABLE = 6;
    localparam int CTL_SEL_DIS = 5;
    localparam int CTL_MASTER = 4;
    localparam int CTL_CPOL = 3;
    localparam int CTL_CPHA = 2;
    localparam int CTL_RATE1 = 1;
    localparam int CTL_RATE0 = 0;
    localparam int STA_DONE = 7;
    localparam int STA_COLL = 6;
    localparam int STA_SEL_ERR = 5;
    localparam int STA_FAULT = 4;
    localparam int IEN_GLOBAL = 7;
    localparam int IEN_PORT = 1;
    localparam int OD_SCK = 4;
    localparam int OD_MOSI = 3;
    localparam int OD_MISO = 2;
    localparam int DIR_SCK = 6;
    localparam int DIR_MOSI = 5;
    localparam int DIR_MISO = 4;
    localparam int DIR_SEL = 3;

    // ******************************
    // reset values and counts
    // ******************************
    localparam logic [7:0] CONTROL_RST = 8'h14;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [7:0] OPEN_DRAIN_RST = 8'h00;
    localparam logic [7:0] DIRECTION_RST = 8'h00;
    localparam logic [2:0] RATE_MAX = 3'h6;
    localparam logic [3:0] EDGE_LAST = 4'hF;

    // ******************************
    // types
    // ******************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smp_bus_type;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic sel_n;
    } smp_pins_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } smp_state_type;

endpackage : smp_pkg

// ### smp_sync2.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs are asynchronous to ref_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module smp_sync2 #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= '0;
            sync_out <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end

endmodule : smp_sync2

// ### smp_port_chk.sv
// Purpose: port-level assertions for smp_port
// Assumes: config registers mirrored from bus writes
// Notes: bound to the design from tb_top
`timescale 1ns/10ps
module smp_port_chk
    import smp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // observed ports
    input wire smp_bus_type bus,
    input wire logic [7:0] rd_data,
    input wire smp_pins_type pin_in,
    input wire smp_pins_type pin_out,
    input wire smp_pins_type pin_oe,
    input wire logic irq
);
    // ******************************
    // register mirror
    // ******************************
    logic [7:0] ctl_reg;
    logic [7:0] dir_reg;
    logic [7:0] od_reg;
    logic [7:0] ie0_reg;
    logic [7:0] ie1_reg;
    logic [3:0] dir_oe;
    assign dir_oe = {dir_reg[DIR_SCK], dir_reg[DIR_MOSI], dir_reg[DIR_MISO], dir_reg[DIR_SEL]};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl_reg <= CONTROL_RST;
            dir_reg <= DIRECTION_RST;
            od_reg <= OPEN_DRAIN_RST;
            ie0_reg <= IRQ_EN_RST;
            ie1_reg <= IRQ_EN_RST;
        end else if (bus.wr) begin
            case (bus.addr)
                ADDR_CONTROL: ctl_reg <= bus.wdata;
                ADDR_DIRECTION: dir_reg <= bus.wdata;
                ADDR_OPEN_DRAIN: od_reg <= bus.wdata;
                ADDR_IRQ_EN_LOW: ie0_reg <= bus.wdata;
                ADDR_IRQ_EN_HIGH: ie1_reg <= bus.wdata;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] a);
        bus.rd && bus.addr == a;
    endsequence
    sequence s_rd_off;
        bus.rd && !ctl_reg[CTL_ENABLE] && (bus.addr == ADDR_STATUS || bus.addr == ADDR_DATA);
    endsequence
    property p_low_zero;
        s_rd(ADDR_STATUS) |=> rd_data[3:0] == 4'h0;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("status low bits set");
    property p_off_read;
        s_rd_off |=> rd_data == 8'h00;
    endproperty
    a_off_read: assert property (p_off_read) else $error("read while disabled");
    property p_glb_mask;
        !ie0_reg[IEN_GLOBAL] && !$past(ie0_reg[IEN_GLOBAL]) |-> !irq;
    endproperty
    a_glb_mask: assert property (p_glb_mask) else $error("irq without global");
    property p_port_mask;
        !ie1_reg[IEN_PORT] && !$past(ie1_reg[IEN_PORT]) |-> !irq;
    endproperty
    a_port_mask: assert property (p_port_mask) else $error("irq without port");
    property p_dir_oe;
        $stable(dir_oe) && $stable(od_reg) && od_reg == 8'h00 |=> pin_oe == $past(dir_oe);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("enable off direction");
    property p_od_low;
        od_reg[OD_SCK] && $past(od_reg[OD_SCK]) |-> !pin_out.sck;
    endproperty
    a_od_low: assert property (p_od_low) else $error("open drain drives high");
    property p_dir_rd;
        s_rd(ADDR_DIRECTION) |=> rd_data[6:3] == $past(dir_reg[6:3]);
    endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("direction readback");
    property p_od_rd;
        s_rd(ADDR_OPEN_DRAIN) |=> rd_data[4:2] == $past(od_reg[4:2]);
    endproperty
    a_od_rd: assert property (p_od_rd) else $error("open drain readback");
endmodule : smp_port_chk

// ### smp_peer.sv
// Purpose: far-side serial device, slave or master
// Assumes: clock idles low
// Notes: master frames run at a 160 ns clock period
`timescale 1ns/10ps
module smp_peer (
    // bus levels
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    // drive values
    output logic p_sck,
    output logic p_mosi,
    output logic p_miso,
    output logic p_sel_n,
    output logic m_oe
);
    logic [7:0] s_tx;
    logic [7:0] s_rx;
    initial begin
        p_sck = 1'b0;
        p_mosi = 1'b1;
        p_miso = 1'b1;
        p_sel_n = 1'b1;
        m_oe = 1'b0;
        s_tx = 8'h00;
        s_rx = 8'h00;
    end
    // slave: shift out on leading edge, sample on trailing
    always @(posedge sck) if (!m_oe) begin
        p_miso <= s_tx[7];
        s_tx <= {s_tx[6:0], 1'b0};
    end
    always @(negedge sck) if (!m_oe) s_rx <= {s_rx[6:0], mosi};
    // master frame of n bits; k keeps select low afterwards
    task automatic mx(input logic [7:0] t, input int n, input bit ph, input bit k,
                      output logic [7:0] r);
        r = 8'h00;
        m_oe = 1'b1;
        p_sel_n = 1'b0;
        p_mosi = t[7];
        #83;
        for (int i = 0; i < n; i++) begin
            if (ph) p_mosi = t[7-i];
            p_sck = 1'b1;
            if (!ph) r = {r[6:0], miso};
            #80;
            p_sck = 1'b0;
            if (ph) r = {r[6:0], miso};
            else if (i < 7) p_mosi = t[6-i];
            #80;
        end
        p_mosi = ~p_mosi;
        if (!k) p_sel_n = 1'b1;
        #80;
    endtask : mx
endmodule : smp_peer

// ### tb_top.sv
// Purpose: self-checking bench for smp_port
// Assumes: peer model on the far side of the pins
// Notes: pull-down on sck, pull-ups on data lines
`timescale 1ns/10ps
module tb_top
    import smp_pkg::*;
;
    logic ref_clk;
    logic rst;
    smp_bus_type bus;
    logic [7:0] rd_data;
    smp_pins_type pin_in;
    smp_pins_type pin_out;
    smp_pins_type pin_oe;
    logic irq;
    logic p_sck;
    logic p_mosi;
    logic p_miso;
    logic p_sel_n;
    logic m_oe;
    logic [7:0] v;
    int miscompares;
    int checks_done;
    assign pin_in = {pin_oe.sck ? pin_out.sck : (m_oe & p_sck),
                     pin_oe.mosi ? pin_out.mosi : (!m_oe | p_mosi),
                     pin_oe.miso ? pin_out.miso : (m_oe | p_miso),
                     pin_oe.sel_n ? pin_out.sel_n : p_sel_n};
    smp_port u_dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
    smp_peer u_peer (.sck(pin_in.sck), .mosi(pin_in.mosi), .miso(pin_in.miso), .p_sck(p_sck),
        .p_mosi(p_mosi), .p_miso(p_miso), .p_sel_n(p_sel_n), .m_oe(m_oe));
    always #2.5 ref_clk = ~ref_clk;
    // ******************************
    // bus tasks and checks
    // ******************************
    task automatic end_of_test;
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
        logic [7:0] d;
        rd(a, d);
        chk(n, d, e);
    endtask : rdc
    task automatic wst(output logic [7:0] s);
        for (int i = 0; i < 300; i++) begin
            rd(ADDR_STATUS, s);
            if (s[STA_DONE] || s[STA_FAULT]) return;
        end
        miscompares++;
        end_of_test();
    endtask : wst
    // ******************************
    // scenarios
    // ******************************
    task automatic t_regs;
        rdc(ADDR_CONTROL, CONTROL_RST, "control");
        rdc(ADDR_DIRECTION, DIRECTION_RST, "direction");
        rdc(ADDR_OPEN_DRAIN, OPEN_DRAIN_RST, "open_drain");
        rdc(ADDR_IRQ_EN_LOW, IRQ_EN_RST, "ien_low");
        rdc(8'h00, 8'h00, "unmapped");
        rdc(ADDR_STATUS, 8'h00, "status_off");
        wr(ADDR_DATA, 8'h5A);
        wr(ADDR_CONTROL, 8'h57);
        wr(ADDR_STATUS, 8'hFF);
        rdc(ADDR_STATUS, 8'h00, "status_ro");
        rdc(ADDR_DATA, DATA_RST, "data_off");
    endtask : t_regs
    task automatic t_pins;
        wr(ADDR_DIRECTION, 8'h78);
        rdc(ADDR_DIRECTION, 8'h78, "dir_rd");
        cyc(3);
        chk("oe_all", {4'h0, pin_oe}, 8'h0F);
        wr(ADDR_OPEN_DRAIN, 8'h1C);
        rdc(ADDR_OPEN_DRAIN, 8'h1C, "od_rd");
        wr(ADDR_CONTROL, 8'h5F);
        cyc(3);
        chk("od_high", {6'h00, pin_out.sck, pin_oe.sck}, 8'h00);
        wr(ADDR_CONTROL, 8'h57);
        cyc(3);
        chk("od_low", {6'h00, pin_out.sck, pin_oe.sck}, 8'h01);
        wr(ADDR_OPEN_DRAIN, 8'h00);
        wr(ADDR_DIRECTION, 8'h60);
    endtask : t_pins
    task automatic t_master;
        u_peer.s_tx = 8'h66;
        wr(ADDR_IRQ_EN_HIGH, 8'h02);
        wr(ADDR_DATA, 8'h55);
        wr(ADDR_DATA, 8'h99);
        wst(v);
        chk("done_coll", v, 8'hC0);
        chk("irq_glb", {7'h00, irq}, 8'h00);
        wr(ADDR_IRQ_EN_LOW, 8'h80);
        cyc(2);
        chk("irq_on", {7'h00, irq}, 8'h01);
        rdc(ADDR_DATA, 8'h66, "rx_master");
        chk("peer_rx", u_peer.s_rx, 8'h55);
        rdc(ADDR_STATUS, 8'h00, "cleared");
        wr(ADDR_IRQ_EN_HIGH, 8'h00);
        u_peer.s_tx = 8'hAA;
        wr(ADDR_DATA, 8'h99);
        wst(v);
        cyc(2);
        chk("irq_port", {7'h00, irq}, 8'h00);
        wr(ADDR_IRQ_EN_HIGH, 8'h02);
        cyc(2);
        chk("irq_port_on", {7'h00, irq}, 8'h01);
        rdc(ADDR_DATA, 8'hAA, "rx_second");
    endtask : t_master
    task automatic t_fault;
        u_peer.p_sel_n = 1'b0;
        wr(ADDR_DATA, 8'h11);
        wst(v);
        chk("fault", v, 8'h10);
        u_peer.p_sel_n = 1'b1;
        rd(ADDR_DATA, v);
        rdc(ADDR_STATUS, 8'h00, "fault_clr");
        wr(ADDR_CONTROL, 8'h77);
        u_peer.p_sel_n = 1'b0;
        wr(ADDR_DATA, 8'h22);
        wst(v);
        chk("fault_mask", v, 8'h80);
        chk("peer_rx_mask", u_peer.s_rx, 8'h22);
        u_peer.p_sel_n = 1'b1;
        rd(ADDR_DATA, v);
    endtask : t_fault
    task automatic t_slave;
        wr(ADDR_DIRECTION, 8'h10);
        wr(ADDR_CONTROL, 8'h44);
        wr(ADDR_DATA, 8'hA5);
        u_peer.mx(8'h3C, 8, 1'b1, 1'b0, v);
        chk("slave_tx", v, 8'hA5);
        rdc(ADDR_STATUS, 8'h80, "slave_done");
        rdc(ADDR_DATA, 8'h3C, "slave_rx");
        u_peer.mx(8'hF0, 4, 1'b1, 1'b0, v);
        rdc(ADDR_STATUS, 8'h10, "slave_fault");
        rd(ADDR_DATA, v);
    endtask : t_slave
    task automatic t_sel;
        wr(ADDR_CONTROL, 8'h40);
        u_peer.mx(8'h81, 8, 1'b0, 1'b1, v);
        u_peer.mx(8'h00, 1, 1'b0, 1'b1, v);
        rdc(ADDR_STATUS, 8'hA0, "sel_err");
        rd(ADDR_DATA, v);
        rdc(ADDR_STATUS, 8'h20, "sel_keep");
        wr(ADDR_CONTROL, 8'h00);
        u_peer.p_sel_n = 1'b1;
        cyc(4);
        wr(ADDR_CONTROL, 8'h40);
        rdc(ADDR_STATUS, 8'h00, "sel_clr");
    endtask : t_sel
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        bus = '0;
        miscompares = 0;
        checks_done = 0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_pins();
        t_master();
        t_fault();
        t_slave();
        t_sel();
        end_of_test();
    end
endmodule : tb_top
bind smp_port smp_port_chk u_chk (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
